// ---- inc/wdog_pkg.sv ----
// Package of constants and types for the watchdog event manager.
package wdog_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SECURE = 8'h0c;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_STBY_BIT = 1;
  localparam int CTRL_PINMODE_BIT = 2;
  localparam int CTRL_SECURE_BIT = 3;
  localparam int CFG_DUR_LSB = 0;
  localparam int CFG_MAX_LSB = 4;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_CNT_LSB = 4;
  localparam int STAT_EVT_BIT = 8;

  localparam logic [7:0] SECURE_KEY = 8'ha5;
  localparam logic [2:0] EXP_FAIL_STEP = 3'h2;
  localparam logic [2:0] EXP_OK_STEP = 3'h1;
  localparam logic [2:0] MAX_FIRST_LIMIT = 3'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_COUNT = 4'b0010,
    ST_EVENT = 4'b0100,
    ST_OFF = 4'b1000
  } wd_state_t;

  typedef struct packed {
    logic valid;
    logic hard;
  } wd_event_t;

  typedef struct packed {
    logic [3:0] duration;
    logic [2:0] max_expiry;
    logic enable;
    logic standby_enable;
    logic window_mode;
  } wd_fuse_t;

endpackage

// ---- rtl/pmic_watchdog_event_manager.sv ----
// Watchdog supervision and event generation logic.
`timescale 1ns/1ps
// Functional notes
// - A falling edge on the watchdog input pin starts a watchdog event.
// - A pin event requests hard or soft reset per the pin reset-type select.
// - A timer event always requests a hard reset.
// - Timer counts up and expires on reaching the selected duration.
// - Starting the timer sets the refresh-pending flag.
// - Writing one to the pending flag in window restarts the timer from zero.
// - The pending flag is not cleared by a write; host writes one to refresh and the restart sets it again.
// - Off states reset the timer; it idles until processor reset releases.
// - Duration default comes from fuses; windows span 1 ms to 32768 ms.
// - Writing a changed duration while on resets the timer.
// - Each successful refresh decrements the expiry counter by one.
// - Each expiry restarts the timer and adds two to the expiry counter.
// - Expiry counter at or above maximum setting starts an event; default from fuses.
// - Maximum default of two or less gives an event on first expiry.
// - Window mode zero accepts refresh across the whole period.
// - Window mode one accepts only second half; early clear is a failure.
// - Enable bit zero stops the timer, one lets it run.
// - With secure mode set, enable changes need a secure write.
// - Enable default loads from fuses at power-up.
// - Standby enable is host writable, secure-write only when secure mode set.
// - Standby enable zero stops the timer in standby, one keeps it running.
module pmic_watchdog_event_manager
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic watchdog_input_pin,
  input wire logic processor_reset_output,
  input wire logic system_on,
  input wire logic standby_state,
  input wire logic event_done,
  input wire wd_fuse_t fuse_in,
  output wd_event_t wd_event
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Both pins come from outside the clock domain, so each passes two flip-flops first.
  logic [1:0] pin_sync_reg;
  logic [1:0] rst_sync_reg;
  logic pin_prev_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync_reg <= 2'b11;
      rst_sync_reg <= 2'b00;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], watchdog_input_pin};
      rst_sync_reg <= {rst_sync_reg[0], processor_reset_output};
      pin_prev_reg <= pin_sync_reg[1];
    end
  end

  logic pin_fall;
  assign pin_fall = pin_prev_reg & ~pin_sync_reg[1];
  logic proc_released;
  assign proc_released = rst_sync_reg[1];

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic fuse_loaded_reg;
  logic enable_reg;
  logic stby_en_reg;
  logic pin_mode_reg;
  logic secure_mode_reg;
  logic window_mode_reg;
  logic [3:0] duration_reg;
  logic [2:0] max_exp_reg;
  logic unlock_reg;
  logic pending_reg;
  logic [2:0] expiry_counter;

  logic wr_ctrl, wr_cfg, wr_stat, wr_secure;
  assign wr_ctrl = reg_write && (reg_addr == ADDR_CTRL);
  assign wr_cfg = reg_write && (reg_addr == ADDR_CONFIG);
  assign wr_stat = reg_write && (reg_addr == ADDR_STATUS);
  assign wr_secure = reg_write && (reg_addr == ADDR_SECURE);

  logic guarded_ok;
  assign guarded_ok = !secure_mode_reg || unlock_reg;

  logic dur_changed;
  assign dur_changed = wr_cfg && system_on &&
                       (reg_wdata[CFG_DUR_LSB +: 4] != duration_reg);

  // Fuse values are sampled one cycle after reset release, never under reset.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fuse_loaded_reg <= 1'b0;
      enable_reg <= 1'b0;
      stby_en_reg <= 1'b0;
      window_mode_reg <= 1'b0;
      duration_reg <= 4'h0;
      max_exp_reg <= 3'h0;
    end else if (!fuse_loaded_reg) begin
      fuse_loaded_reg <= 1'b1;
      enable_reg <= fuse_in.enable;
      stby_en_reg <= fuse_in.standby_enable;
      window_mode_reg <= fuse_in.window_mode;
      duration_reg <= fuse_in.duration;
      max_exp_reg <= fuse_in.max_expiry;
    end else begin
      if (wr_ctrl && guarded_ok) begin
        enable_reg <= reg_wdata[CTRL_EN_BIT];
        stby_en_reg <= reg_wdata[CTRL_STBY_BIT];
      end
      if (wr_cfg) begin
        duration_reg <= reg_wdata[CFG_DUR_LSB +: 4];
        max_exp_reg <= reg_wdata[CFG_MAX_LSB +: 3];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_mode_reg <= 1'b0;
      secure_mode_reg <= 1'b0;
    end else if (wr_ctrl) begin
      pin_mode_reg <= reg_wdata[CTRL_PINMODE_BIT];
      secure_mode_reg <= reg_wdata[CTRL_SECURE_BIT];
    end
  end

  // The unlock lasts for exactly one following write, so a stray write cannot use it.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unlock_reg <= 1'b0;
    end else if (wr_secure) begin
      unlock_reg <= (reg_wdata[7:0] == SECURE_KEY);
    end else if (reg_write) begin
      unlock_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  localparam int TW = $clog2(TICK_LEN + 1);
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  logic timer_restart;
  assign tick = (tick_cnt_reg == TW'(TICK_LEN - 1));

  // The tick restarts with the timer, so every period is a whole number of ticks.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= '0;
    end else if (timer_restart || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
    end
  end

  // ****************************************************************
  // Watchdog timer and expiry counter
  // ****************************************************************
  function automatic logic [15:0] window_ms(input logic [3:0] code);
    window_ms = 16'h0001 << code;
  endfunction

  wd_state_t state_reg;
  logic [15:0] ms_cnt_reg;
  logic run_ok;
  logic expire;
  logic refresh;
  logic refresh_good;
  logic [15:0] limit;

  assign run_ok = enable_reg && (!standby_state || stby_en_reg);
  assign limit = window_ms(duration_reg);
  assign expire = (state_reg == ST_COUNT) && run_ok && tick &&
                  (ms_cnt_reg + 16'h0001 >= limit);
  assign refresh = wr_stat && reg_wdata[STAT_PEND_BIT] && pending_reg &&
                   (state_reg == ST_COUNT);
  assign refresh_good = !window_mode_reg || (ms_cnt_reg >= (limit >> 1));
  assign timer_restart = refresh || expire || dur_changed || state_reg != ST_COUNT;

  logic fail_event;
  logic count_fail;
  logic [2:0] cnt_next;

  assign count_fail = expire || (refresh && !refresh_good);

  always_comb begin
    cnt_next = expiry_counter;
    if (count_fail) begin
      cnt_next = (expiry_counter > 3'h7 - EXP_FAIL_STEP) ? 3'h7 :
                 expiry_counter + EXP_FAIL_STEP;
    end else if (refresh) begin
      cnt_next = (expiry_counter == 3'h0) ? 3'h0 : expiry_counter - EXP_OK_STEP;
    end
  end

  // At least the maximum, not only equal, so a step of two cannot jump past it.
  // event on limit
  assign fail_event = count_fail &&
                      ((cnt_next >= max_exp_reg) || (max_exp_reg <= MAX_FIRST_LIMIT));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF: state_reg <= (system_on && proc_released) ? ST_IDLE : ST_OFF;
        ST_IDLE: begin
          if (!system_on) begin
            state_reg <= ST_OFF;
          end else if (pin_fall || (run_ok && fuse_loaded_reg)) begin
            state_reg <= pin_fall ? ST_EVENT : ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (!system_on) begin
            state_reg <= ST_OFF;
          end else if (pin_fall || fail_event) begin
            state_reg <= ST_EVENT;
          end else if (!run_ok) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_EVENT: state_reg <= event_done ? ST_OFF : ST_EVENT;
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_reg <= 16'h0000;
    end else if (timer_restart) begin
      ms_cnt_reg <= 16'h0000;
    end else if (run_ok && tick) begin
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

  // The pending flag is set on every timer start; a fresh start beats a clear.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg <= 1'b0;
    end else if (state_reg == ST_COUNT && timer_restart) begin
      pending_reg <= 1'b1;
    end else if (state_reg == ST_IDLE && run_ok && system_on) begin
      pending_reg <= 1'b1;
    end else if (state_reg != ST_COUNT) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      expiry_counter <= 3'h0;
    end else if (state_reg == ST_OFF) begin
      expiry_counter <= 3'h0;
    end else begin
      expiry_counter <= cnt_next;
    end
  end

  // ****************************************************************
  // Event output
  // ****************************************************************
  logic pin_event;
  assign pin_event = (state_reg == ST_COUNT || state_reg == ST_IDLE) &&
                     system_on && pin_fall;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wd_event <= '0;
    end else if (state_reg == ST_EVENT) begin
      wd_event.valid <= !event_done;
    end else if (pin_event) begin
      wd_event.valid <= 1'b1;
      wd_event.hard <= pin_mode_reg;
    end else if (state_reg == ST_COUNT && system_on && fail_event) begin
      wd_event.valid <= 1'b1;
      wd_event.hard <= 1'b1;
    end else begin
      wd_event.valid <= 1'b0;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Read data falls back to zero outside the answer cycle, so a stale word never looks fresh.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= {12'h000, secure_mode_reg, pin_mode_reg,
                                 stby_en_reg, enable_reg};
        ADDR_CONFIG: reg_rdata <= {8'h00, 1'b0, max_exp_reg, duration_reg};
        ADDR_STATUS: reg_rdata <= {7'h00, wd_event.valid, 1'b0, expiry_counter,
                                   3'h0, pending_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ---- dv/wdog_host_model.sv ----
// Behavioural model of the reset sequencer and processor facing the watchdog.
`timescale 1ns/1ps
module wdog_host_model
  import wdog_pkg::*;
#(
  parameter int DONE_DELAY = 6
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire wd_event_t wd_event,
  output logic event_done,
  output logic processor_reset_output,
  output logic system_on
);
  int wait_cnt;
  // ****************************************
  // Event handling
  // ****************************************
  // processor held on hard reset.
  // A hard request pulls the processor into reset, so the timer must idle until release.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 0;
      event_done <= 1'b0;
      processor_reset_output <= 1'b0;
      system_on <= 1'b0;
    end else if (wd_event.valid && !event_done) begin
      wait_cnt <= wait_cnt + 1;
      event_done <= (wait_cnt == DONE_DELAY);
      if (wd_event.hard) begin
        processor_reset_output <= 1'b0;
      end
    end else begin
      wait_cnt <= 0;
      event_done <= 1'b0;
      system_on <= 1'b1;
      processor_reset_output <= system_on;
    end
  end
endmodule

// ---- dv/wdog_event_chk.sv ----
// Port-level assertions for the watchdog event manager.
`timescale 1ns/1ps
module wdog_event_chk
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_LEN = 4
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic watchdog_input_pin,
  input wire logic processor_reset_output,
  input wire logic system_on,
  input wire logic standby_state,
  input wire logic event_done,
  input wire wd_fuse_t fuse_in,
  input wire wd_event_t wd_event
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic mapped;
  assign mapped = reg_addr inside {ADDR_CTRL, ADDR_CONFIG, ADDR_STATUS, ADDR_SECURE};
  sequence pin_quiet_s;
    watchdog_input_pin [*8];
  endsequence
  sequence evt_start_s;
    $rose(wd_event.valid);
  endsequence
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (reg_read && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_event_holds: assert property (wd_event.valid && !event_done |=> wd_event.valid)
    else $error("event dropped before done");
  a_type_stable: assert property (wd_event.valid && $past(wd_event.valid) |->
    wd_event.hard == $past(wd_event.hard)) else $error("reset type changed in event");
  a_pin_starts: assert property ($fell(watchdog_input_pin) && system_on &&
    processor_reset_output && $past(processor_reset_output, 4) && !wd_event.valid &&
    !event_done |-> ##[1:6] wd_event.valid) else $error("pin fall gave no event");
  a_timer_hard: assert property (pin_quiet_s ##1 evt_start_s |-> wd_event.hard)
    else $error("timer event not hard");
  a_done_clears: assert property (event_done && wd_event.valid |-> ##[1:3] !wd_event.valid)
    else $error("event not cleared after done");
  a_cfg_readback: assert property (reg_write && reg_addr == ADDR_CONFIG ##2
    reg_read && reg_addr == ADDR_CONFIG |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 3))
    else $error("config readback wrong");
  a_status_event: assert property (reg_read && reg_addr == ADDR_STATUS &&
    wd_event.valid && !event_done |=> reg_rdata[STAT_EVT_BIT]) else $error("event flag low");
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the watchdog event manager.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("FAIL %0t got %h expected %h", $time, (got), (exp)); end end
module tb_top;
  import wdog_pkg::*;
  localparam int unsigned TICK_LEN = 4;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic watchdog_input_pin = 1'b1;
  logic processor_reset_output;
  logic system_on;
  logic event_done;
  logic standby_state = 1'b0;
  wd_fuse_t fuse_in = {4'h2, 3'h4, 1'b1, 1'b1, 1'b0};
  wd_event_t wd_event;
  logic [15:0] rd_val;
  int err_count = 0;
  int n_checks = 0;
  int mode;
  always #2 clk_sys = ~clk_sys;
  pmic_watchdog_event_manager #(.TICK_LEN(TICK_LEN)) uut (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .watchdog_input_pin(watchdog_input_pin),
    .processor_reset_output(processor_reset_output), .system_on(system_on),
    .standby_state(standby_state), .event_done(event_done), .fuse_in(fuse_in),
    .wd_event(wd_event));
  wdog_host_model host (.clk_sys(clk_sys), .reset_n(reset_n), .wd_event(wd_event),
    .event_done(event_done), .processor_reset_output(processor_reset_output),
    .system_on(system_on));
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Bounded wait; a missed event would otherwise hang the run.
  task automatic wait_lvl(input logic lvl, input int lim);
    for (int i = 0; i < lim && wd_event.valid !== lvl; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (wd_event.valid !== lvl) begin
      err_count++;
      $display("FAIL %0t event level wait ran out", $time);
      complete_run();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(ADDR_CTRL);
    `CHK(rd_val[1:0], 2'b11)
    rd(ADDR_CONFIG);
    `CHK(rd_val[6:0], 7'h42)
    rd(8'h10);
    `CHK(rd_val, 16'h0000)
    rd(ADDR_STATUS);
    `CHK(rd_val[STAT_PEND_BIT], 1'b1)
    wr(ADDR_STATUS, 16'h0001);
    repeat (20) @(posedge clk_sys);
    rd(ADDR_STATUS);
    `CHK(rd_val[6:4], 3'h2)
    wr(ADDR_STATUS, 16'h0001);
    rd(ADDR_STATUS);
    `CHK(rd_val[6:4], 3'h1)
    wait_lvl(1'b1, 200);
    `CHK(wd_event.hard, 1'b1)
    rd(ADDR_STATUS);
    `CHK(rd_val[STAT_EVT_BIT], 1'b1)
    wait_lvl(1'b0, 40);
    repeat (8) @(posedge clk_sys);
    wr(ADDR_CONFIG, 16'h0073);
    rd(ADDR_CONFIG);
    `CHK(rd_val[6:0], 7'h73)
    repeat (16) @(posedge clk_sys);
    wr(ADDR_CONFIG, 16'h0072);
    repeat (6) @(posedge clk_sys);
    rd(ADDR_STATUS);
    `CHK(rd_val[6:4], 3'h0)
    wr(ADDR_CONFIG, 16'h0022);
    rd(ADDR_CONFIG);
    `CHK(rd_val[6:0], 7'h22)
    wr(ADDR_STATUS, 16'h0001);
    wait_lvl(1'b1, 26);
    wait_lvl(1'b0, 40);
    wr(ADDR_CONFIG, 16'h007f);
    for (mode = 0; mode < 2; mode++) begin
      repeat (12) @(posedge clk_sys);
      wr(ADDR_CTRL, mode ? 16'h0007 : 16'h0003);
      watchdog_input_pin <= 1'b0;
      wait_lvl(1'b1, 10);
      `CHK(wd_event.hard, mode[0])
      @(posedge clk_sys);
      watchdog_input_pin <= 1'b1;
      wait_lvl(1'b0, 40);
    end
    repeat (12) @(posedge clk_sys);
    wr(ADDR_CTRL, 16'h0001);
    standby_state <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(ADDR_STATUS);
    `CHK(rd_val[STAT_PEND_BIT], 1'b0)
    wr(ADDR_CTRL, 16'h0003);
    repeat (4) @(posedge clk_sys);
    rd(ADDR_STATUS);
    `CHK(rd_val[STAT_PEND_BIT], 1'b1)
    standby_state <= 1'b0;
    wr(ADDR_CTRL, 16'h000b);
    wr(ADDR_CTRL, 16'h0008);
    rd(ADDR_CTRL);
    `CHK(rd_val[1:0], 2'b11)
    wr(ADDR_SECURE, {8'h00, SECURE_KEY});
    wr(ADDR_CTRL, 16'h0008);
    rd(ADDR_CTRL);
    `CHK(rd_val[1:0], 2'b00)
    wr(ADDR_STATUS, 16'h0001);
    repeat (10) @(posedge clk_sys);
    rd(ADDR_STATUS);
    `CHK(rd_val[STAT_PEND_BIT], 1'b0)
    // Second reset in mid-run with window mode set in the fuses.
    @(posedge clk_sys);
    reset_n <= 1'b0;
    fuse_in <= {4'h2, 3'h7, 1'b1, 1'b1, 1'b1};
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(ADDR_CONFIG);
    `CHK(rd_val[6:0], 7'h72)
    wr(ADDR_STATUS, 16'h0001);
    rd(ADDR_STATUS);
    `CHK(rd_val[6:4], 3'h2)
    repeat (8) @(posedge clk_sys);
    wr(ADDR_STATUS, 16'h0001);
    rd(ADDR_STATUS);
    `CHK(rd_val[6:4], 3'h1)
    complete_run();
  end
endmodule
bind pmic_watchdog_event_manager wdog_event_chk #(.TICK_LEN(TICK_LEN)) chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .watchdog_input_pin(watchdog_input_pin), .processor_reset_output(processor_reset_output),
  .system_on(system_on), .standby_state(standby_state), .event_done(event_done),
  .fuse_in(fuse_in), .wd_event(wd_event));
